// file: hw/pbc_regs_top.v
// Management slave and basic control, status and identifier registers.
// Assumes MDC and MDIO are far slower than ref_clk; straps are static levels.
`timescale 1ns/100ps
`include "pbc_consts.vh"
module pbc_regs_top #(
   parameter [4:0]  PHY_ADDR = `PBC_PHY_ADDR_DEF,
   parameter [15:0] ID_HIGH  = `PBC_ID_HIGH_DEF
) (
   input  wire ref_clk,
   input  wire rst,
   input  wire mdc,
   input  wire mdioIn,
   output reg  mdioOut,
   output reg  mdioOe,
   input  wire speedStrap,
   input  wire anegStrap,
   input  wire isoStrap,
   input  wire duplexStrap,
   input  wire linkUp,
   input  wire remoteFault,
   input  wire jabber,
   input  wire anegDone,
   input  wire anegSpeed100,
   input  wire anegFullDuplex,
   output reg  softResetPulse,
   output reg  anegRestart,
   output reg  anegEnable,
   output reg  loopbackEn,
   output reg  speed100,
   output reg  fullDuplex,
   output reg  macIsolate,
   output reg  lineTxOff,
   output reg  coreEnable,
   output reg  colTestEn
);
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_CMD  = 6'h02;
   localparam [5:0] S_TA1  = 6'h04;
   localparam [5:0] S_TA2  = 6'h08;
   localparam [5:0] S_RD   = 6'h10;
   localparam [5:0] S_WR   = 6'h20;

   wire [5:0]  syncBus;
   wire        mdcS;
   wire        mdioS;
   wire        speedStrapS;
   wire        anegStrapS;
   wire        isoStrapS;
   wire        duplexStrapS;
   reg         mdcPrev_r;
   wire        mdcRise;
   reg  [5:0]  state_r;
   reg  [3:0]  bitCnt_r;
   reg  [11:0] cmd_r;
   reg  [15:0] shift_r;
   reg         prevBit_r;
   reg         isWrite_r;
   reg         skip_r;
   reg         wrStb_r;
   reg  [15:0] wrData_r;
   reg  [4:0]  wrAddr_r;
   reg         rdClr_r;
   reg  [1:0]  strapCnt_r;
   wire        loadDef;
   reg         speedSel_r;
   reg         powerDown_r;
   reg         isolate_r;
   reg         duplex_r;
   reg         txDisable_r;
   reg         resetPend_r;
   reg         rfLatch_r;
   reg         jabLatch_r;
   reg         linkLatch_r;
   reg         linkPrev_r;
   reg         linkHold_r;
   reg         anegDone_r;
   wire [1:0]  cmdOp;
   wire [4:0]  cmdPhy;
   wire [4:0]  cmdReg;
   wire        statusRead;

   pbc_sync #(
      .WIDTH (6)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .asyncIn ({mdc, mdioIn, speedStrap, anegStrap, isoStrap, duplexStrap}),
      .syncOut (syncBus)
   );

   assign mdcS         = syncBus[5];
   assign mdioS        = syncBus[4];
   assign speedStrapS  = syncBus[3];
   assign anegStrapS   = syncBus[2];
   assign isoStrapS    = syncBus[1];
   assign duplexStrapS = syncBus[0];
   assign mdcRise      = mdcS & ~mdcPrev_r;
   assign cmdOp        = cmd_r[11:10];
   assign cmdPhy       = cmd_r[9:5];
   assign cmdReg       = cmd_r[4:0];
   assign statusRead   = (cmdReg == `PBC_REG_STATUS);

   function [15:0] readMux;
      input [4:0] addr;
      begin
         if (addr == `PBC_REG_CONTROL) begin
            readMux = 16'h0000;
            readMux[`PBC_CTL_RESET]    = resetPend_r;
            readMux[`PBC_CTL_LOOPBACK] = loopbackEn;
            readMux[`PBC_CTL_SPEED]    = speedSel_r;
            readMux[`PBC_CTL_ANEG_EN]  = anegEnable;
            readMux[`PBC_CTL_PWR_DOWN] = powerDown_r;
            readMux[`PBC_CTL_ISOLATE]  = isolate_r;
            readMux[`PBC_CTL_RESTART]  = anegRestart;
            readMux[`PBC_CTL_DUPLEX]   = duplex_r;
            readMux[`PBC_CTL_COL_TEST] = colTestEn;
            readMux[`PBC_CTL_TX_DIS]   = txDisable_r;
         end else if (addr == `PBC_REG_STATUS) begin
            readMux = `PBC_STAT_FIXED;
            readMux[`PBC_STAT_ANEG_DONE] = anegDone_r;
            readMux[`PBC_STAT_RFAULT]    = rfLatch_r;
            readMux[`PBC_STAT_LINK]      = linkLatch_r;
            readMux[`PBC_STAT_JABBER]    = jabLatch_r;
         end else if (addr == `PBC_REG_ID_HIGH) begin
            readMux = ID_HIGH;
         end else begin
            readMux = 16'h0000;
         end
      end
   endfunction

   // Frame engine; preamble is optional, so a start is any zero followed by a one.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mdcPrev_r <= 1'b0;
         state_r   <= S_IDLE;
         bitCnt_r  <= 4'h0;
         cmd_r     <= 12'h000;
         shift_r   <= 16'h0000;
         prevBit_r <= 1'b1;
         isWrite_r <= 1'b0;
         skip_r    <= 1'b0;
         wrStb_r   <= 1'b0;
         wrData_r  <= 16'h0000;
         wrAddr_r  <= 5'h00;
         rdClr_r   <= 1'b0;
         mdioOut   <= 1'b0;
         mdioOe    <= 1'b0;
      end else begin
         mdcPrev_r <= mdcS;
         wrStb_r   <= 1'b0;
         rdClr_r   <= 1'b0;
         if (mdcRise) begin
            case (state_r)
               S_IDLE: begin
                  prevBit_r <= mdioS;
                  bitCnt_r  <= 4'h0;
                  if (!prevBit_r && mdioS) begin
                     state_r <= S_CMD;
                  end
               end
               S_CMD: begin
                  cmd_r <= {cmd_r[10:0], mdioS};
                  if (bitCnt_r == `PBC_CMD_LAST) begin
                     state_r <= S_TA1;
                  end else begin
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end
               end
               S_TA1: begin
                  prevBit_r <= 1'b1;
                  if (cmdPhy == PHY_ADDR && cmdOp == `PBC_OP_READ) begin
                     mdioOe    <= 1'b1;
                     mdioOut   <= 1'b0;
                     shift_r   <= readMux(cmdReg);
                     rdClr_r   <= statusRead;
                     isWrite_r <= 1'b0;
                     state_r   <= S_TA2;
                  end else if (cmdPhy == PHY_ADDR && cmdOp == `PBC_OP_WRITE) begin
                     isWrite_r <= 1'b1;
                     skip_r    <= 1'b0;
                     state_r   <= S_TA2;
                  end else begin
                     // A foreign frame is clocked through so its data cannot fake a start.
                     isWrite_r <= 1'b1;
                     skip_r    <= 1'b1;
                     state_r   <= S_TA2;
                  end
               end
               S_TA2: begin
                  bitCnt_r <= 4'h0;
                  if (isWrite_r) begin
                     state_r <= S_WR;
                  end else begin
                     mdioOut <= shift_r[15];
                     shift_r <= {shift_r[14:0], 1'b0};
                     state_r <= S_RD;
                  end
               end
               S_RD: begin
                  if (bitCnt_r == `PBC_DATA_LAST) begin
                     mdioOe  <= 1'b0;
                     mdioOut <= 1'b0;
                     state_r <= S_IDLE;
                  end else begin
                     mdioOut  <= shift_r[15];
                     shift_r  <= {shift_r[14:0], 1'b0};
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end
               end
               S_WR: begin
                  shift_r <= {shift_r[14:0], mdioS};
                  if (bitCnt_r == `PBC_DATA_LAST) begin
                     wrStb_r  <= ~skip_r;
                     wrData_r <= {shift_r[14:0], mdioS};
                     wrAddr_r <= cmdReg;
                     state_r  <= S_IDLE;
                  end else begin
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end
               end
               default: begin
                  state_r <= S_IDLE;
               end
            endcase
         end
      end
   end

   // Straps are caught once the synchroniser has settled after release.
   assign loadDef = (strapCnt_r == `PBC_STRAP_LOAD) | resetPend_r;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strapCnt_r     <= 2'h0;
         loopbackEn     <= 1'b0;
         speedSel_r     <= 1'b0;
         anegEnable     <= 1'b0;
         powerDown_r    <= 1'b0;
         isolate_r      <= 1'b0;
         anegRestart    <= 1'b0;
         duplex_r       <= 1'b0;
         colTestEn      <= 1'b0;
         txDisable_r    <= 1'b0;
         resetPend_r    <= 1'b0;
         softResetPulse <= 1'b0;
      end else begin
         if (strapCnt_r != `PBC_STRAP_DONE) begin
            strapCnt_r <= strapCnt_r + 2'h1;
         end
         softResetPulse <= resetPend_r;
         if (loadDef) begin
            loopbackEn  <= 1'b0;
            speedSel_r  <= speedStrapS;
            anegEnable  <= anegStrapS;
            powerDown_r <= 1'b0;
            isolate_r   <= isoStrapS;
            anegRestart <= 1'b0;
            duplex_r    <= ~duplexStrapS;
            colTestEn   <= 1'b0;
            txDisable_r <= 1'b0;
            resetPend_r <= 1'b0;
         end else if (wrStb_r && wrAddr_r == `PBC_REG_CONTROL) begin
            // Reserved and read-only bits are simply not stored.
            loopbackEn  <= wrData_r[`PBC_CTL_LOOPBACK];
            speedSel_r  <= wrData_r[`PBC_CTL_SPEED];
            anegEnable  <= wrData_r[`PBC_CTL_ANEG_EN];
            powerDown_r <= wrData_r[`PBC_CTL_PWR_DOWN];
            isolate_r   <= wrData_r[`PBC_CTL_ISOLATE];
            anegRestart <= wrData_r[`PBC_CTL_RESTART];
            duplex_r    <= wrData_r[`PBC_CTL_DUPLEX];
            colTestEn   <= wrData_r[`PBC_CTL_COL_TEST];
            txDisable_r <= wrData_r[`PBC_CTL_TX_DIS];
            resetPend_r <= wrData_r[`PBC_CTL_RESET];
         end else begin
            anegRestart <= 1'b0;
         end
      end
   end

   // Latched status: a new event in the read cycle wins over the read-clear.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rfLatch_r   <= 1'b0;
         jabLatch_r  <= 1'b0;
         linkLatch_r <= 1'b0;
         linkPrev_r  <= 1'b0;
         linkHold_r  <= 1'b0;
         anegDone_r  <= 1'b0;
      end else begin
         rfLatch_r   <= remoteFault | (rfLatch_r & ~rdClr_r);
         jabLatch_r  <= jabber | (jabLatch_r & ~rdClr_r);
         // Only a drop is held; a read taken while the link is down must not pin it low.
         linkPrev_r  <= linkUp;
         linkHold_r  <= (linkPrev_r & ~linkUp) | (linkHold_r & ~rdClr_r);
         linkLatch_r <= linkUp & ~(linkHold_r & ~rdClr_r);
         anegDone_r  <= anegDone & anegEnable & ~anegRestart;
      end
   end

   // Operating outputs; power down leaves the management path above running.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         speed100   <= 1'b0;
         fullDuplex <= 1'b0;
         macIsolate <= 1'b0;
         lineTxOff  <= 1'b0;
         coreEnable <= 1'b0;
      end else begin
         speed100   <= anegEnable ? anegSpeed100 : speedSel_r;
         fullDuplex <= anegEnable ? anegFullDuplex : duplex_r;
         macIsolate <= isolate_r;
         lineTxOff  <= isolate_r | txDisable_r | powerDown_r;
         coreEnable <= ~powerDown_r;
      end
   end
endmodule

// file: hw/pbc_consts.vh
// Constants for the basic control, status and first identifier register set.
// Assumes inclusion by bare name from every design file of this block.
//
// Operation
// - Writing one to control bit 15 starts a software reset; the bit self-clears.
// - Writing one to the restart bit restarts negotiation; the bit self-clears.
// - Speed select picks 100 or 10 Mbps, ignored while negotiation is enabled.
// - With negotiation enabled, the negotiated speed and duplex take over.
// - Speed select loads its default from the speed strap.
// - Negotiation enable and isolate load their defaults from their straps.
// - Isolate cuts the MAC interface and the line transmitter off.
// - Duplex selects full when one; default is the inverted duplex strap.
// - Collision test bit enables the collision signal test; resets to zero.
// - Lowest control bit disables the line transmitter; resets to zero.
// - Capability bits read fixed: T4 zero, four speed and duplex bits one.
// - Preamble suppression bit reads one.
// - Negotiation complete reads one only once negotiation has finished.
// - Remote fault and jabber latch high until read; reset to zero.
// - Link status latches low until read, then follows the link.
// - Negotiation ability bit reads a constant one.
// - Extended capability bit reads a constant one.
// - First identifier register is a read-only sixteen bit identifier slice.
// - Power down stops everything except the management interface; here it only clears coreEnable and sets lineTxOff.
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH

`define PBC_REG_CONTROL   5'h00
`define PBC_REG_STATUS    5'h01
`define PBC_REG_ID_HIGH   5'h02

`define PBC_CTL_RESET     15
`define PBC_CTL_LOOPBACK  14
`define PBC_CTL_SPEED     13
`define PBC_CTL_ANEG_EN   12
`define PBC_CTL_PWR_DOWN  11
`define PBC_CTL_ISOLATE   10
`define PBC_CTL_RESTART   9
`define PBC_CTL_DUPLEX    8
`define PBC_CTL_COL_TEST  7
`define PBC_CTL_TX_DIS    0

`define PBC_STAT_FIXED    16'h7849
`define PBC_STAT_ANEG_DONE 5
`define PBC_STAT_RFAULT   4
`define PBC_STAT_LINK     2
`define PBC_STAT_JABBER   1

// Value is arbitrary.
`define PBC_ID_HIGH_DEF   16'h5a3c
// Value is arbitrary.
`define PBC_PHY_ADDR_DEF  5'h01

`define PBC_OP_WRITE      2'h1
`define PBC_OP_READ       2'h2
`define PBC_CMD_LAST      4'hb
`define PBC_DATA_LAST     4'hf

`define PBC_STRAP_LOAD    2'h2
`define PBC_STRAP_DONE    2'h3

`endif

// file: hw/pbc_sync.v
// Two-stage synchroniser for a bundle of asynchronous level inputs.
// Assumes each bit is an independent level; multi-bit coherence is not kept.
`timescale 1ns/100ps
`include "pbc_consts.vh"
module pbc_sync #(
   parameter WIDTH = 6
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] asyncIn,
   output reg  [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stage1_r;

   // Only the second stage reads the first, to keep metastability contained.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage1_r <= {WIDTH{1'b0}};
         syncOut  <= {WIDTH{1'b0}};
      end else begin
         stage1_r <= asyncIn;
         syncOut  <= stage1_r;
      end
   end
endmodule

// file: tb/pbc_mdio_master.sv
// Behavioural station management controller on the serial management pins.
// Assumes the device drives mdioOut under mdioOe and the line has a pull-up.
`timescale 1ns/100ps
module pbc_mdio_master (
   output logic mdc,
   output wire  mdioLine,
   input  wire  mdioOut,
   input  wire  mdioOe
);
   logic mstOut;
   logic mstOe;
   // A released line rises to the pull-up level instead of keeping its last value.
   assign mdioLine = mdioOe ? mdioOut : (mstOe ? mstOut : 1'b1);
   initial begin
      mdc = 1'b0;
      mstOut = 1'b1;
      mstOe = 1'b0;
   end
   // The clock runs only inside a frame and rests low between frames.
   task automatic bit_cycle(input logic oe, input logic b, output logic s);
      mstOe = oe;
      mstOut = b;
      #62.5 mdc = 1'b1;
      s = mdioLine;
      #62.5 mdc = 1'b0;
   endtask
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [15:0] hdr;
      logic        s;
      logic        wrOp;
      wrOp = (op != 2'b10);
      hdr = {4'b1101, op, phy, ra};
      for (int i = 15; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
      bit_cycle(wrOp, 1'b1, s);
      bit_cycle(wrOp, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_cycle(wrOp, wd[i], s);
         rd[i] = s;
      end
      bit_cycle(1'b0, 1'b1, s);
      bit_cycle(1'b0, 1'b1, s);
   endtask
endmodule

// file: tb/pbc_regs_monitor.sv
// Concurrent checks on the ports of the register set's top module.
// Assumes one ref_clk domain with rst asynchronous and active high.
`timescale 1ns/100ps
module pbc_regs_monitor (
   input wire ref_clk,
   input wire rst,
   input wire mdioOe,
   input wire anegSpeed100,
   input wire anegFullDuplex,
   input wire softResetPulse,
   input wire anegRestart,
   input wire anegEnable,
   input wire loopbackEn,
   input wire speed100,
   input wire fullDuplex,
   input wire macIsolate,
   input wire lineTxOff,
   input wire coreEnable,
   input wire colTestEn
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_restart_pulse: assert property (anegRestart |=> !anegRestart)
      else $error("restart pulse longer than one cycle");
   a_softrst_pulse: assert property (softResetPulse |=> !softResetPulse)
      else $error("software reset pulse longer than one cycle");
   a_aneg_speed: assert property ((anegEnable && $stable(anegEnable)
      && $stable(anegSpeed100))[*3] |-> speed100 == anegSpeed100)
      else $error("speed does not follow negotiated result");
   a_aneg_duplex: assert property ((anegEnable && $stable(anegEnable)
      && $stable(anegFullDuplex))[*3] |-> fullDuplex == anegFullDuplex)
      else $error("duplex does not follow negotiated result");
   a_iso_tx_off: assert property ($rose(macIsolate) |-> ##[0:2] lineTxOff)
      else $error("isolate left the transmitter on");
   a_pd_tx_off: assert property ($fell(coreEnable) |-> ##[0:2] lineTxOff)
      else $error("power down left the transmitter on");
   a_sw_reload: assert property (softResetPulse |-> ##[0:3]
      (!colTestEn && !loopbackEn && coreEnable))
      else $error("software reset did not reload control defaults");
   a_tx_reload: assert property (softResetPulse |-> ##[0:3] (lineTxOff == macIsolate))
      else $error("transmit disable not cleared by software reset");
   a_oe_stands: assert property ($rose(mdioOe) |-> mdioOe[*8])
      else $error("read drive released too early");
   c_soft: cover property (softResetPulse);
   c_restart: cover property (anegRestart);
   c_pdown: cover property ($fell(coreEnable));
   c_read: cover property ($rose(mdioOe));
endmodule

// file: tb/testbench.sv
// Register-level bench for the basic control, status and identifier set.
// Assumes pbc_consts.vh on the include path and the management master model.
`timescale 1ns/100ps
`include "pbc_consts.vh"
module testbench;
   logic ref_clk = 1'b0, rst = 1'b1;
   logic speedStrap = 1'b1, anegStrap = 1'b0, isoStrap = 1'b0, duplexStrap = 1'b0;
   logic linkUp = 1'b0, remoteFault = 1'b0, jabber = 1'b0;
   logic anegDone = 1'b0, anegSpeed100 = 1'b1, anegFullDuplex = 1'b1;
   wire  mdc, mdioLine, mdioOut, mdioOe, softResetPulse, anegRestart, anegEnable;
   wire  loopbackEn, speed100, fullDuplex, macIsolate, lineTxOff, coreEnable, colTestEn;
   wire  [7:0] mode;
   int   n_fail = 0, comparisons = 0, nRestart = 0, nSoft = 0;
   logic [15:0] rv;
   assign mode = {loopbackEn, speed100, fullDuplex, macIsolate,
                  lineTxOff, coreEnable, colTestEn, anegEnable};
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      nRestart += anegRestart;
      nSoft += softResetPulse;
   end
   pbc_regs_top i_dut (.ref_clk, .rst, .mdc, .mdioIn(mdioLine), .mdioOut, .mdioOe,
      .speedStrap, .anegStrap, .isoStrap, .duplexStrap, .linkUp, .remoteFault, .jabber,
      .anegDone, .anegSpeed100, .anegFullDuplex, .softResetPulse, .anegRestart,
      .anegEnable, .loopbackEn, .speed100, .fullDuplex, .macIsolate, .lineTxOff,
      .coreEnable, .colTestEn);
   pbc_mdio_master i_mst (.mdc, .mdioLine, .mdioOut, .mdioOe);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] d;
      i_mst.frame(`PBC_OP_READ, `PBC_PHY_ADDR_DEF, ra, 16'h0000, d);
      chk(d, exp);
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
      logic [15:0] d;
      i_mst.frame(`PBC_OP_WRITE, `PBC_PHY_ADDR_DEF, ra, wd, d);
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      repeat (20) @(negedge ref_clk);
      rd(`PBC_REG_CONTROL, 16'h2100);
      chk({8'h00, mode}, 16'h0064);
      rd(`PBC_REG_ID_HIGH, `PBC_ID_HIGH_DEF);
      rd(`PBC_REG_STATUS, `PBC_STAT_FIXED);
      @(negedge ref_clk) linkUp = 1'b1;
      rd(`PBC_REG_STATUS, 16'h784d);
      @(negedge ref_clk) linkUp = 1'b0;
      @(negedge ref_clk) linkUp = 1'b1;
      remoteFault = 1'b1;
      jabber = 1'b1;
      @(negedge ref_clk) remoteFault = 1'b0;
      jabber = 1'b0;
      rd(`PBC_REG_STATUS, 16'h785b);
      rd(`PBC_REG_STATUS, 16'h784d);
      wr(`PBC_REG_ID_HIGH, 16'hffff);
      wr(`PBC_REG_STATUS, 16'h0000);
      rd(`PBC_REG_ID_HIGH, `PBC_ID_HIGH_DEF);
      rd(`PBC_REG_STATUS, 16'h784d);
      rd(5'h05, 16'h0000);
      // A frame for another address must leave the line at its pull-up level.
      i_mst.frame(`PBC_OP_READ, 5'h02, `PBC_REG_ID_HIGH, 16'h0000, rv);
      chk(rv, 16'hffff);
      // A foreign write whose data holds a zero then a one must not start a frame.
      i_mst.frame(`PBC_OP_WRITE, 5'h02, `PBC_REG_CONTROL, 16'h5555, rv);
      rd(`PBC_REG_CONTROL, 16'h2100);
      wr(`PBC_REG_CONTROL, 16'h4cff);
      rd(`PBC_REG_CONTROL, 16'h4c81);
      chk({8'h00, mode}, 16'h009a);
      wr(`PBC_REG_CONTROL, 16'h0001);
      chk({8'h00, mode}, 16'h000c);
      @(negedge ref_clk) anegDone = 1'b1;
      anegSpeed100 = 1'b0;
      anegFullDuplex = 1'b0;
      wr(`PBC_REG_CONTROL, 16'h2000);
      chk({8'h00, mode}, 16'h0044);
      rd(`PBC_REG_STATUS, 16'h784d);
      wr(`PBC_REG_CONTROL, 16'h3100);
      chk({8'h00, mode}, 16'h0005);
      rd(`PBC_REG_STATUS, 16'h786d);
      @(negedge ref_clk) anegSpeed100 = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({8'h00, mode}, 16'h0045);
      wr(`PBC_REG_CONTROL, 16'h3300);
      rd(`PBC_REG_CONTROL, 16'h3100);
      chk(nRestart[15:0], 16'h0001);
      @(negedge ref_clk) speedStrap = 1'b0;
      anegStrap = 1'b1;
      isoStrap = 1'b1;
      duplexStrap = 1'b1;
      wr(`PBC_REG_CONTROL, 16'hc081);
      rd(`PBC_REG_CONTROL, 16'h1400);
      chk(nSoft[15:0], 16'h0001);
      chk({8'h00, mode}, 16'h005d);
      close_out();
   end
   // The full sequence needs about 113 us, so this leaves ample margin.
   initial begin
      #300000;
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      close_out();
   end
endmodule
bind pbc_regs_top pbc_regs_monitor i_mon (.ref_clk, .rst, .mdioOe, .anegSpeed100,
   .anegFullDuplex, .softResetPulse, .anegRestart, .anegEnable, .loopbackEn, .speed100,
   .fullDuplex, .macIsolate, .lineTxOff, .coreEnable, .colTestEn);
